// >>> src/srpo_top.sv
`timescale 1ns/100ps
`include "srpo_consts.svh"

// Contract
// - relay closes while selected condition true
// - relay codes 0..27, 21 unused, 0 never
// - unit ready: card powered and ready
// - idle-ready and running-clean without warning
// - running: start or above 0.1 Hz
// - supply in range with no control input
// - alarm-or-warning and alarm-only conditions
// - current above programmed limit
// - six threshold comparison conditions
// - frequency, current, feedback outside window
// - reversing follows anticlockwise rotation
// - thermal warning from limits or thermistor
// - local operation when local bit set
// - relay bus code follows control bit 11
// - sleep below 0.1 Hz
// - digital output selector code map
// - status codes level, pulse codes frequency
// - full scale 150..10000 Hz, default 5000
// - pulse rate proportional over span
// - power pulse full scale at motor power
// - temperature pulse 20 to 100 degrees
// - no pulse rate below 16 Hz
// - digital bus code follows control bit 12
module srpo_top (
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter status, same clock
    input wire logic cardPowered,
    input wire logic unitReady,
    input wire logic startCmd,
    input wire logic warningActive,
    input wire logic alarmActive,
    input wire logic onReference,
    input wire logic ctrlInputActive,
    input wire logic mainsInRange,
    input wire logic reverseRotation,
    input wire logic motorOverTemp,
    input wire logic inverterOverTemp,
    input wire logic thermistorTrip,
    input wire logic relayBusReq,
    input wire logic brakeRelease,
    input wire logic [15:0] busControlWord,
    // process values
    input wire logic [15:0] outFreq,
    input wire logic [15:0] outCurrent,
    input wire logic [15:0] feedback,
    input wire logic [15:0] reference,
    input wire logic [15:0] outPower,
    input wire logic [7:0] heatsinkTemp,
    // status outputs
    output logic relayClosed,
    output logic digitalOut
);
    localparam int UPD = `SRPO_UPDATE_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] ctrl_q;
    logic [13:0] fullScale_q;
    logic [31:0] freqWin_q;
    logic [31:0] curWin_q;
    logic [31:0] fbWin_q;
    logic [15:0] curLimit_q;
    logic [31:0] refSpan_q;
    logic [31:0] fbSpan_q;
    logic [31:0] scale_q;
    logic [15:0] motorPower_q;
    logic [31:0] rdData_q;
    logic [7:0] tick_q;
    logic [27:0] cond_q;
    logic doLevel_q;
    logic pulseOn;
    logic [13:0] pulseFreq;

    ////////////////////////////////////////////////////////////////////////
    // field views
    wire [4:0] relaySel = ctrl_q[`SRPO_CTRL_RELAY_LSB +: 5];
    wire [5:0] doSel = ctrl_q[`SRPO_CTRL_DO_LSB +: 6];
    wire localMode = ctrl_q[`SRPO_CTRL_LOCAL_BIT];
    wire [15:0] freqLo = freqWin_q[15:0];
    wire [15:0] freqHi = freqWin_q[31:16];
    wire [15:0] curLo = curWin_q[15:0];
    wire [15:0] curHi = curWin_q[31:16];
    wire [15:0] feedback_low_threshold = fbWin_q[15:0];
    wire [15:0] feedback_high_threshold = fbWin_q[31:16];
    wire [15:0] feedback_minimum = fbSpan_q[15:0];
    wire [15:0] feedback_maximum = fbSpan_q[31:16];
    wire [15:0] refMin = refSpan_q[15:0];
    wire [15:0] refMax = refSpan_q[31:16];
    wire [15:0] freqMax = scale_q[15:0];
    wire [15:0] rated_inverter_current = scale_q[31:16];

    ////////////////////////////////////////////////////////////////////////
    // apb decode, zero wait states
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hitCtrl = paddr == `SRPO_OFF_CTRL;
    wire hitFs = paddr == `SRPO_OFF_PULSE_FS;
    wire hitFreqWin = paddr == `SRPO_OFF_FREQ_WIN;
    wire hitCurWin = paddr == `SRPO_OFF_CUR_WIN;
    wire hitFbWin = paddr == `SRPO_OFF_FB_WIN;
    wire hitCurLim = paddr == `SRPO_OFF_CUR_LIMIT;
    wire hitRefSpan = paddr == `SRPO_OFF_REF_SPAN;
    wire hitFbSpan = paddr == `SRPO_OFF_FB_SPAN;
    wire hitScale = paddr == `SRPO_OFF_SCALE;
    wire hitPwr = paddr == `SRPO_OFF_MOTOR_PWR;
    wire hitStat = paddr == `SRPO_OFF_STATUS;
    wire hitPHz = paddr == `SRPO_OFF_PULSE_HZ;
    wire hitAny = hitCtrl | hitFs | hitFreqWin | hitCurWin | hitFbWin |
                  hitCurLim | hitRefSpan | hitFbSpan | hitScale | hitPwr |
                  hitStat | hitPHz;
    wire wrEn = access && pwrite && hitAny;
    assign pready = 1'b1;
    assign pslverr = access && !hitAny;
    assign prdata = rdData_q;

    // full-scale writes are clamped into range
    wire [13:0] fsWr = pwdata[13:0];
    wire fsHigh = (pwdata[31:14] != '0) || (fsWr > `SRPO_FS_MAX);
    wire [13:0] fsClamp = fsHigh ? `SRPO_FS_MAX :
                          (fsWr < `SRPO_FS_MIN) ? `SRPO_FS_MIN : fsWr;

    ////////////////////////////////////////////////////////////////////////
    // status word seen by software
    wire [31:0] statusWord = {1'b0, pulseOn, digitalOut, relayClosed, cond_q};

    // read data is captured in setup so it comes from a flop in access
    wire [31:0] rdMux =
        hitCtrl ? {15'h0000, ctrl_q[16:0]} :
        hitFs ? {18'h00000, fullScale_q} :
        hitFreqWin ? freqWin_q :
        hitCurWin ? curWin_q :
        hitFbWin ? fbWin_q :
        hitCurLim ? {16'h0000, curLimit_q} :
        hitRefSpan ? refSpan_q :
        hitFbSpan ? fbSpan_q :
        hitScale ? scale_q :
        hitPwr ? {16'h0000, motorPower_q} :
        hitStat ? statusWord :
        hitPHz ? {18'h00000, pulseFreq} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers, written only in the access phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= `SRPO_RST_CTRL;
            fullScale_q <= `SRPO_RST_FS;
            freqWin_q <= {`SRPO_RST_HI, `SRPO_RST_LO};
            curWin_q <= {`SRPO_RST_HI, `SRPO_RST_LO};
            fbWin_q <= {`SRPO_RST_HI, `SRPO_RST_LO};
            curLimit_q <= `SRPO_RST_HI;
            refSpan_q <= {`SRPO_RST_HI, `SRPO_RST_LO};
            fbSpan_q <= {`SRPO_RST_HI, `SRPO_RST_LO};
            scale_q <= {`SRPO_RST_HI, `SRPO_RST_HI};
            motorPower_q <= `SRPO_RST_HI;
        end else if (wrEn) begin
            if (hitCtrl) ctrl_q <= {15'h0000, pwdata[16:0]};
            if (hitFs) fullScale_q <= fsClamp;
            if (hitFreqWin) freqWin_q <= pwdata;
            if (hitCurWin) curWin_q <= pwdata;
            if (hitFbWin) fbWin_q <= pwdata;
            if (hitCurLim) curLimit_q <= pwdata[15:0];
            if (hitRefSpan) refSpan_q <= pwdata;
            if (hitFbSpan) fbSpan_q <= pwdata;
            if (hitScale) scale_q <= pwdata;
            if (hitPwr) motorPower_q <= pwdata[15:0];
        end
    end

    // read capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdData_q <= 32'h0000_0000;
        end else if (setup) begin
            rdData_q <= pwrite ? 32'h0000_0000 : rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control update enable
    wire tick = tick_q == 8'(UPD - 1);
    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            tick_q <= 8'h00;
        end else begin
            tick_q <= tick_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparisons; frequency is counted in tenths of a hertz
    // running threshold
    wire running = startCmd || (outFreq > `SRPO_RUN_FREQ);
    wire sleeping = outFreq < `SRPO_RUN_FREQ;
    wire fAboveLo = outFreq > freqLo;
    wire fBelowHi = outFreq < freqHi;
    wire iAboveLo = outCurrent > curLo;
    wire iBelowHi = outCurrent < curHi;
    wire bAboveLo = feedback > feedback_low_threshold;
    wire bBelowHi = feedback < feedback_high_threshold;
    wire fInWin = (outFreq >= freqLo) && (outFreq <= freqHi);
    wire iInWin = (outCurrent >= curLo) && (outCurrent <= curHi);
    wire bInWin = (feedback >= feedback_low_threshold) &&
                  (feedback <= feedback_high_threshold);
    wire ready = cardPowered && unitReady;

    ////////////////////////////////////////////////////////////////////////
    // condition vector indexed by relay code
    wire [27:0] cond;
    assign cond[0] = 1'b0;
    assign cond[1] = ready;
    assign cond[2] = ready && !startCmd && !warningActive;
    assign cond[3] = running;
    assign cond[4] = running && onReference && !warningActive;
    assign cond[5] = startCmd && !warningActive;
    assign cond[6] = running && !warningActive && fInWin && iInWin && bInWin;
    assign cond[7] = ready && !ctrlInputActive && mainsInRange;
    assign cond[8] = alarmActive || warningActive;
    assign cond[9] = outCurrent > curLimit_q;
    assign cond[10] = alarmActive;
    assign cond[11] = fAboveLo;
    assign cond[12] = fBelowHi;
    assign cond[13] = iAboveLo;
    assign cond[14] = iBelowHi;
    assign cond[15] = bAboveLo;
    assign cond[16] = bBelowHi;
    assign cond[17] = relayBusReq;
    assign cond[18] = reverseRotation;
    assign cond[19] = motorOverTemp || inverterOverTemp || thermistorTrip;
    assign cond[20] = localMode;
    assign cond[21] = 1'b0;
    assign cond[22] = !fInWin;
    assign cond[23] = !iInWin;
    assign cond[24] = !bInWin;
    assign cond[25] = brakeRelease;
    assign cond[26] = busControlWord[`SRPO_CW_RELAY_BIT];
    assign cond[27] = sleeping;

    ////////////////////////////////////////////////////////////////////////
    // relay selection
    wire relayPick = (relaySel <= `SRPO_RELAY_LAST) ? cond[relaySel] : 1'b0;

    wire doIsPulse = (doSel == `SRPO_DO_REF) ||
                     ((doSel >= `SRPO_DO_FB) && (doSel <= `SRPO_DO_TEMP));
    wire doStatusCode = (doSel < `SRPO_DO_REF) ||
                        ((doSel > `SRPO_DO_REF) && (doSel < `SRPO_DO_FB));
    wire doPick = (doSel == 6'h00) ? cond[1] :
                  doStatusCode ? cond[doSel[4:0]] :
                  (doSel == `SRPO_DO_CW) ? busControlWord[`SRPO_CW_DO_BIT] :
                  (doSel == `SRPO_DO_SLEEP) ? sleeping : 1'b0;
    assign pulseOn = doIsPulse;

    // conditions sampled on every update, never latched
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cond_q <= '0;
            relayClosed <= 1'b0;
            doLevel_q <= 1'b0;
        end else if (tick) begin
            cond_q <= cond;
            relayClosed <= relayPick;
            doLevel_q <= doPick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse source selection
    // spans for reference, feedback, frequency, current
    // power spans zero to motor power
    // temperature spans 20 to 100 degrees
    wire selRef = doSel == `SRPO_DO_REF;
    wire selFb = doSel == `SRPO_DO_FB;
    wire selFreq = doSel == `SRPO_DO_FREQ;
    wire selCur = doSel == `SRPO_DO_CUR;
    wire selPwr = doSel == `SRPO_DO_PWR;
    wire [15:0] srcVal = selRef ? reference :
                         selFb ? feedback :
                         selFreq ? outFreq :
                         selCur ? outCurrent :
                         selPwr ? outPower : {8'h00, heatsinkTemp};
    wire [15:0] srcLo = selRef ? refMin :
                        selFb ? feedback_minimum :
                        (selFreq || selCur || selPwr) ? 16'h0000 :
                        {8'h00, `SRPO_TEMP_LO};
    wire [15:0] srcHi = selRef ? refMax :
                        selFb ? feedback_maximum :
                        selFreq ? freqMax :
                        selCur ? rated_inverter_current :
                        selPwr ? motorPower_q : {8'h00, `SRPO_TEMP_HI};

    // target recomputed every update; division ends well within one
    srpo_pulse_scale #(
        .W(16),
        .FW(14)
    ) u_scale (
        .clk(ref_clk),
        .rst(rst),
        .start(tick && doIsPulse),
        .value(srcVal),
        .spanLo(srcLo),
        .spanHi(srcHi),
        .fullScale(fullScale_q),
        .freqHz(pulseFreq)
    );

    // generator is held idle outside pulse mode
    logic ncoOut;
    wire [13:0] ncoFreq = doIsPulse ? pulseFreq : 14'h0000;
    srpo_pulse_nco #(
        .FW(14),
        .AW(27)
    ) u_nco (
        .clk(ref_clk),
        .rst(rst),
        .freqHz(ncoFreq),
        .pulseOut(ncoOut)
    );

    ////////////////////////////////////////////////////////////////////////
    // pulse train or status level on the digital output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            digitalOut <= 1'b0;
        end else begin
            digitalOut <= doIsPulse ? ncoOut : doLevel_q;
        end
    end
endmodule

// >>> pkg/srpo_consts.svh
`ifndef SRPO_CONSTS_SVH
`define SRPO_CONSTS_SVH

// clock and update timing
`define SRPO_CLK_HZ 200000000
`define SRPO_CLK_PERIOD_NS 5
`define SRPO_UPDATE_NS 1000
`define SRPO_UPDATE_CYCLES (`SRPO_UPDATE_NS / `SRPO_CLK_PERIOD_NS)
`define SRPO_NCO_HALF (`SRPO_CLK_HZ / 2)

// register byte offsets
`define SRPO_OFF_CTRL 12'h000
`define SRPO_OFF_PULSE_FS 12'h004
`define SRPO_OFF_FREQ_WIN 12'h008
`define SRPO_OFF_CUR_WIN 12'h00c
`define SRPO_OFF_FB_WIN 12'h010
`define SRPO_OFF_CUR_LIMIT 12'h014
`define SRPO_OFF_REF_SPAN 12'h018
`define SRPO_OFF_FB_SPAN 12'h01c
`define SRPO_OFF_SCALE 12'h020
`define SRPO_OFF_MOTOR_PWR 12'h024
`define SRPO_OFF_STATUS 12'h028
`define SRPO_OFF_PULSE_HZ 12'h02c

// control register fields and status word bits
`define SRPO_CTRL_RELAY_LSB 0
`define SRPO_CTRL_DO_LSB 8
`define SRPO_CTRL_LOCAL_BIT 16
`define SRPO_STAT_RELAY_BIT 28
`define SRPO_STAT_DO_BIT 29
`define SRPO_STAT_PMODE_BIT 30

// reset values
`define SRPO_RST_CTRL 32'h0000_0000
`define SRPO_RST_FS 14'h1388
`define SRPO_RST_LO 16'h0000
`define SRPO_RST_HI 16'hffff

// limits and scaling
`define SRPO_FS_MIN 14'h0096
`define SRPO_FS_MAX 14'h2710
`define SRPO_PULSE_MIN_HZ 14'h0010
`define SRPO_RUN_FREQ 16'h0001
`define SRPO_TEMP_LO 8'h14
`define SRPO_TEMP_HI 8'h64
`define SRPO_CW_RELAY_BIT 11
`define SRPO_CW_DO_BIT 12

// selector codes
`define SRPO_RELAY_LAST 5'h1b
`define SRPO_DO_REF 6'h15
`define SRPO_DO_FB 6'h1a
`define SRPO_DO_FREQ 6'h1b
`define SRPO_DO_CUR 6'h1c
`define SRPO_DO_PWR 6'h1d
`define SRPO_DO_TEMP 6'h1e
`define SRPO_DO_CW 6'h1f
`define SRPO_DO_SLEEP 6'h20

`endif

// >>> pkg/srpo_pkg.sv
package srpo_pkg;

    // divider sequencer states
    typedef enum logic [1:0] {
        SRPO_IDLE = 2'b01,
        SRPO_DIV = 2'b10
    } srpo_div_state_t;

    // process value word
    typedef logic [15:0] srpo_val_t;

endpackage

// >>> src/srpo_pulse_scale.sv
`timescale 1ns/100ps
`include "srpo_consts.svh"

module srpo_pulse_scale #(
    parameter int W = 16,
    parameter int FW = 14
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] spanLo,
    input wire logic [W-1:0] spanHi,
    input wire logic [FW-1:0] fullScale,
    output logic [FW-1:0] freqHz
);
    localparam int NW = W + FW;

    srpo_pkg::srpo_div_state_t state_q;
    logic [NW-1:0] num_q;
    logic [NW-1:0] quo_q;
    logic [W-1:0] den_q;
    logic [W-1:0] rem_q;
    logic [5:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // clamp the value into its span, so the quotient never passes full scale
    wire spanOk = spanHi > spanLo;
    wire [W-1:0] span = spanHi - spanLo;
    wire [W-1:0] diff = (value <= spanLo) ? '0 :
                        (value >= spanHi) ? span : W'(value - spanLo);
    wire [NW-1:0] prod = NW'(diff) * NW'(fullScale);
    // one restoring division step per clock
    wire [W:0] remSh = {rem_q, num_q[NW-1]};
    wire ge = remSh >= {1'b0, den_q};
    wire [W:0] remSub = remSh - {1'b0, den_q};
    wire [W-1:0] remNx = ge ? remSub[W-1:0] : remSh[W-1:0];
    wire [NW-1:0] quoNx = {quo_q[NW-2:0], ge};
    wire tooSlow = quoNx < NW'(`SRPO_PULSE_MIN_HZ);

    ////////////////////////////////////////////////////////////////////////
    // proportional span division
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= srpo_pkg::SRPO_IDLE;
            num_q <= '0;
            quo_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            cnt_q <= '0;
            freqHz <= '0;
        end else begin
            case (state_q)
                srpo_pkg::SRPO_IDLE: begin
                    if (start && spanOk) begin
                        num_q <= prod;
                        den_q <= span;
                        rem_q <= '0;
                        quo_q <= '0;
                        cnt_q <= 6'(NW);
                        state_q <= srpo_pkg::SRPO_DIV;
                    end else if (start) begin
                        freqHz <= '0; // empty span gives no pulses
                    end
                end
                srpo_pkg::SRPO_DIV: begin
                    num_q <= {num_q[NW-2:0], 1'b0};
                    rem_q <= remNx;
                    quo_q <= quoNx;
                    cnt_q <= cnt_q - 6'h01;
                    if (cnt_q == 6'h01) begin
                        freqHz <= tooSlow ? '0 : quoNx[FW-1:0];
                        state_q <= srpo_pkg::SRPO_IDLE;
                    end
                end
                default: state_q <= srpo_pkg::SRPO_IDLE;
            endcase
        end
    end
endmodule

// >>> src/srpo_pulse_nco.sv
`timescale 1ns/100ps
`include "srpo_consts.svh"

module srpo_pulse_nco #(
    parameter int FW = 14,
    parameter int AW = 27
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [FW-1:0] freqHz,
    output logic pulseOut
);
    localparam logic [AW:0] HALF = (AW+1)'(`SRPO_NCO_HALF);

    logic [AW-1:0] acc_q;

    // accumulating in hertz against half the clock rate gives an exact rate
    wire [AW:0] sum = {1'b0, acc_q} + (AW+1)'(freqHz);
    wire wrap = sum >= HALF;
    wire [AW:0] sumWrap = sum - HALF;

    ////////////////////////////////////////////////////////////////////////
    // square wave at freqHz
    always_ff @(posedge clk) begin
        if (rst || freqHz == '0) begin
            acc_q <= '0;
            pulseOut <= 1'b0;
        end else begin
            acc_q <= wrap ? sumWrap[AW-1:0] : sum[AW-1:0];
            pulseOut <= pulseOut ^ wrap;
        end
    end
endmodule

// >>> tb/srpo_top_chk.sv
`timescale 1ns/100ps
module srpo_top_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] busControlWord,
    input wire logic relayClosed,
    input wire logic digitalOut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [4:0] rSel_q;
    logic [5:0] dSel_q;
    logic [1:0] cw_q;
    logic [9:0] age_q;
    wire acc = psel && penable;
    wire ctrlWr = acc && pwrite && paddr == 12'h000;
    wire moved = ctrlWr || busControlWord[12:11] != cw_q;
    // outputs lag by up to one tick, so judge only after two quiet ticks
    wire settled = age_q > 10'h1a4;
    ////////////////////////////////////////
    // shadow selectors and quiet time since the last selector or bus bit change
    always_ff @(posedge ref_clk) begin
        cw_q <= busControlWord[12:11];
        rSel_q <= rst ? 5'h00 : (ctrlWr ? pwdata[4:0] : rSel_q);
        dSel_q <= rst ? 6'h00 : (ctrlWr ? pwdata[13:8] : dSel_q);
        age_q <= (rst || moved) ? 10'h000 : age_q + {9'h0, !(&age_q)};
    end
    ////////////////////////////////////////
    // bus answers and output relations
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_unmapped_err: assert property (acc && paddr > 12'h02c |-> pslverr)
        else $error("no error on unmapped address");
    chk_mapped_ok: assert property (
        acc && paddr <= 12'h02c && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped address");
    chk_reset_low: assert property (
        disable iff (1'b0) rst |=> !relayClosed && !digitalOut)
        else $error("outputs active after reset");
    chk_relay_hold: assert property (
        $changed(relayClosed) |=> $stable(relayClosed) [*8])
        else $error("relay changed between updates");
    chk_bad_code: assert property (
        settled && (rSel_q == 5'h00 || rSel_q == 5'h15 || rSel_q > 5'h1b) |-> !relayClosed)
        else $error("relay closed on inactive code");
    chk_cw11_relay: assert property (
        settled && rSel_q == 5'h1a |-> relayClosed == busControlWord[11])
        else $error("relay not following bus bit");
    chk_cw12_out: assert property (
        settled && dSel_q == 6'h1f |-> digitalOut == busControlWord[12])
        else $error("digital output not following bus bit");
    chk_do_unused: assert property (settled && dSel_q > 6'h20 |-> !digitalOut)
        else $error("digital output high on unused code");
    cover property (relayClosed && rSel_q == 5'h1a);
    cover property (acc && pslverr);
    cover property ($rose(digitalOut) && dSel_q == 6'h1c);
endmodule

// >>> tb/srpo_pulse_meter.sv
`timescale 1ns/100ps
// external reader timing the pulse train from rise to rise
module srpo_pulse_meter (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic digitalOut,
    output logic [31:0] periodCycles,
    output logic [15:0] riseCount
);
    logic prev_q;
    logic [31:0] cnt_q;
    wire rise = digitalOut && !prev_q;
    ////////////////////////////////////////
    // only whole periods are reported
    always_ff @(posedge ref_clk) begin
        prev_q <= rst ? 1'b0 : digitalOut;
        cnt_q <= (rst || rise) ? 32'h1 : cnt_q + 32'h1;
        periodCycles <= rise ? cnt_q : periodCycles;
        riseCount <= rst ? 16'h0 : riseCount + {15'h0, rise};
    end
endmodule

// >>> tb/srpo_top_tb.sv
`timescale 1ns/100ps
module srpo_top_tb;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, periodCycles, rdData;
    logic pready, pslverr, relayClosed, digitalOut, rdErr;
    logic cardPowered = 1'b1, unitReady = 1'b1, startCmd = 1'b0, warningActive = 1'b0;
    logic alarmActive = 1'b0, onReference = 1'b0, ctrlInputActive = 1'b0, mainsInRange = 1'b1;
    logic reverseRotation = 1'b0, motorOverTemp = 1'b0, inverterOverTemp = 1'b0;
    logic thermistorTrip = 1'b0, relayBusReq = 1'b0, brakeRelease = 1'b0;
    logic [15:0] busControlWord = 16'h0, outFreq = 16'h0, outCurrent = 16'h0, riseCount;
    logic [15:0] feedback = 16'h0, reference = 16'h0, outPower = 16'h0;
    logic [7:0] heatsinkTemp = 8'h0;
    int mismatches = 0, checked = 0;
    always #2.5 ref_clk = ~ref_clk;
    srpo_top srpo_top_inst (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cardPowered, .unitReady, .startCmd, .warningActive,
        .alarmActive, .onReference, .ctrlInputActive, .mainsInRange, .reverseRotation,
        .motorOverTemp, .inverterOverTemp, .thermistorTrip, .relayBusReq, .brakeRelease,
        .busControlWord, .outFreq, .outCurrent, .feedback, .reference, .outPower,
        .heatsinkTemp, .relayClosed, .digitalOut);
    srpo_pulse_meter srpo_pulse_meter_inst (.ref_clk, .rst, .digitalOut, .periodCycles,
        .riseCount);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) hang();
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdData, e);
    endtask
    // select a code, wait two update ticks, then look at relay (m[1]=0) or output
    task automatic cc(input logic [31:0] c, input logic [1:0] m);
        apb(1'b1, 12'h000, c);
        repeat (420) @(posedge ref_clk);
        chk({31'h0, m[1] ? digitalOut : relayClosed}, {31'h0, m[0]});
    endtask
    task automatic pc(input logic [31:0] c, input logic [31:0] hz);
        apb(1'b1, 12'h000, c);
        repeat (420) @(posedge ref_clk);
        rd(12'h02c, hz);
    endtask
    task automatic period(input logic [31:0] e);
        int n = 0;
        logic [15:0] c0;
        c0 = riseCount;
        while (riseCount - c0 < 16'h2 && n < 50000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50000) hang();
        chk(periodCycles, e);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        chk({30'h0, relayClosed, digitalOut}, 32'h0);
        rd(12'h004, 32'h1388);
        apb(1'b0, 12'h030, 32'h0);
        chk({rdErr, rdData[30:0]}, 32'h8000_0000);
        cc(32'h1, 2'h1);
        cc(32'h2, 2'h1);
        cc(32'h3, 2'h0);
        cc(32'h1b, 2'h1);
        cc(32'h0, 2'h0);
        cc(32'h15, 2'h0);
        cc(32'h7, 2'h1);
        ctrlInputActive <= 1'b1;
        cc(32'h7, 2'h0);
        unitReady <= 1'b0;
        cc(32'h1, 2'h0);
        unitReady <= 1'b1;
        cardPowered <= 1'b0;
        cc(32'h1, 2'h0);
        cardPowered <= 1'b1;
        outFreq <= 16'h2;
        cc(32'h3, 2'h1);
        cc(32'h1b, 2'h0);
        startCmd <= 1'b1;
        cc(32'h5, 2'h1);
        cc(32'h2, 2'h0);
        warningActive <= 1'b1;
        cc(32'h5, 2'h0);
        cc(32'h8, 2'h1);
        cc(32'ha, 2'h0);
        alarmActive <= 1'b1;
        cc(32'ha, 2'h1);
        apb(1'b1, 12'h014, 32'h64);
        outCurrent <= 16'h65;
        cc(32'h9, 2'h1);
        outCurrent <= 16'h64;
        cc(32'h9, 2'h0);
        apb(1'b1, 12'h008, 32'h0005_0001);
        cc(32'hb, 2'h1);
        cc(32'h16, 2'h0);
        outFreq <= 16'h6;
        cc(32'hc, 2'h0);
        cc(32'h16, 2'h1);
        apb(1'b1, 12'h010, 32'h0032_000a);
        feedback <= 16'h3c;
        cc(32'h18, 2'h1);
        reverseRotation <= 1'b1;
        cc(32'h12, 2'h1);
        motorOverTemp <= 1'b1;
        cc(32'h13, 2'h1);
        cc(32'h0001_0014, 2'h1);
        cc(32'h14, 2'h0);
        relayBusReq <= 1'b1;
        cc(32'h11, 2'h1);
        busControlWord <= 16'h0800;
        cc(32'h1a, 2'h1);
        busControlWord <= 16'h1000;
        cc(32'h1a, 2'h0);
        cc(32'h1f00, 2'h3);
        cc(32'h2100, 2'h2);
        outFreq <= 16'h0;
        cc(32'h2000, 2'h3);
        apb(1'b1, 12'h004, 32'h4e20);
        rd(12'h004, 32'h2710);
        apb(1'b1, 12'h004, 32'h64);
        rd(12'h004, 32'h96);
        apb(1'b1, 12'h004, 32'h2710);
        apb(1'b1, 12'h020, 32'h03e8_ffff);
        outCurrent <= 16'h3e8;
        pc(32'h1c00, 32'h2710);
        period(32'h4e20);
        outCurrent <= 16'h1f4;
        pc(32'h1c00, 32'h1388);
        heatsinkTemp <= 8'h3c;
        pc(32'h1e00, 32'h1388);
        heatsinkTemp <= 8'h0a;
        pc(32'h1e00, 32'h0);
        apb(1'b1, 12'h024, 32'h3e8);
        outPower <= 16'hfa;
        pc(32'h1d00, 32'h9c4);
        apb(1'b1, 12'h018, 32'h044c_0064);
        reference <= 16'h258;
        pc(32'h1500, 32'h1388);
        apb(1'b1, 12'h004, 32'h96);
        apb(1'b1, 12'h01c, 32'h0064_0000);
        pc(32'h1a00, 32'h5a);
        outCurrent <= 16'h64;
        pc(32'h1c00, 32'h0);
        chk({31'h0, digitalOut}, 32'h0);
        print_verdict();
    end
endmodule
bind srpo_top srpo_top_chk srpo_top_chk_inst (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .busControlWord, .relayClosed, .digitalOut);
